// ---- hdl/flash_crc_pkg.sv ----
// Constants shared by the halt-time flash checksum engine
package flash_crc_pkg;

	// Register byte addresses in the peripheral space
	localparam logic [19:0] FLASH_CRC_CONTROL_ADDR = 20'hF02F0;
	localparam logic [19:0] FLASH_CRC_RESULT_ADDR = 20'hF02F2;

	// Reset values
	localparam logic [7:0] FLASH_CRC_CONTROL_RST = 8'h00;
	localparam logic [15:0] FLASH_CRC_RESULT_RST = 16'h0000;

	// Control register field layout
	localparam int ENGINE_ENABLE_POS = 7;
	localparam int RANGE_CODE_LSB = 0;
	localparam int RANGE_CODE_W = 6;
	localparam logic [5:0] RANGE_CODE_MAX = 6'h0F;

	// Access sizes driven by the core
	localparam logic [1:0] ACC_BIT = 2'h0;
	localparam logic [1:0] ACC_BYTE = 2'h1;
	localparam logic [1:0] ACC_WORD = 2'h2;

	// Checksum generator: x^16 + x^12 + x^5 + 1
	localparam logic [15:0] CRC_POLY = 16'h1021;

	// Flash geometry: one 16 KB step is 4096 words of 4 bytes
	localparam int FLASH_ADDR_W = 18;
	localparam int STEP_WORDS = 4096;
	localparam logic [17:0] WORD_BYTES = 18'h00004;

	// Pass controller states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN
	} pass_state_t;

endpackage

// ---- hdl/crc_word_step.sv ----
// One 32-bit word folded into a CRC-16 remainder, bit 31 first
module crc_word_step
	import flash_crc_pkg::*;
(
	// Remainder before and after the word
	input wire logic [15:0] crc_in,
	input wire logic [31:0] word_in,
	output logic [15:0] crc_out
);

	// Shift function: serial division unrolled over the whole word
	function automatic logic [15:0] fold_word(input logic [15:0] crc, input logic [31:0] word);
		logic [15:0] r;
		logic fb;
		r = crc;
		fb = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			fb = r[15] ^ word[i];
			r = {r[14:0], 1'b0};
			if (fb) begin
				r = r ^ CRC_POLY;
			end
		end
		return r;
	endfunction

	// Purely combinational so a word is absorbed every clock
	always_comb begin
		crc_out = fold_word(crc_in, word_in);
	end

endmodule

// ---- hdl/flash_halt_crc_engine.sv ----
// Halt-time CRC-16 checker of the code flash with its two registers
//
// Contract
// - Checksum uses generator x^16 + x^12 + x^5 + 1.
// - Each 32-bit word enters most significant bit first, bit 31 to 0.
// - With enable set, a halt instruction starts a checksum pass.
// - With enable clear, the unit idles and halt starts nothing.
// - The CPU stays held for the entire pass.
// - The CPU is released automatically when the pass completes.
// - Range code n selects (n+1) x 16 KB; codes above 15 prohibited.
// - Range starts at zero and omits the final four bytes.
// - A pass takes (n+1) x 4096 - 1 clocks, one per word read.
// - Result register holds latest pass checksum, resets to zero.
// - Result writes only take effect while enable is set.
// - Control takes bit writes of enable and byte accesses; resets zero.
// - Result register accepts only whole 16-bit accesses.
// - Security ID areas are read unmasked during a pass.
module flash_halt_crc_engine
	import flash_crc_pkg::*;
#(
	parameter int WORDS_PER_STEP = STEP_WORDS
)
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// Core register access
	input wire logic [19:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [1:0] reg_size_in,
	input wire logic [2:0] reg_bit_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	// Core halt handshake
	input wire logic halt_exec_in,
	output logic cpu_hold_out,
	output logic halt_release_out,
	// Code flash read port, data valid in the same cycle
	output logic flash_rd_out,
	output logic [FLASH_ADDR_W-1:0] flash_addr_out,
	input wire logic [31:0] flash_rdata_in
);

	// Words in a pass for a range code; prohibited codes clamp to the top range
	function automatic logic [15:0] pass_words(input logic [5:0] code);
		logic [5:0] c;
		logic [31:0] n;
		c = (code > RANGE_CODE_MAX) ? RANGE_CODE_MAX : code;
		n = (32'(c) + 32'd1) * 32'(WORDS_PER_STEP) - 32'd1;
		return n[15:0];
	endfunction

	logic enable_q, enable_d;
	logic [5:0] range_q, range_d;
	logic [15:0] result_q, result_d;
	logic [15:0] rdata_q, rdata_d;
	pass_state_t state_q, state_d;
	logic [15:0] left_q, left_d;
	logic [15:0] crc_q, crc_d;
	logic [15:0] crc_next;
	logic hold_q, hold_d;
	logic release_q, release_d;
	logic rd_q, rd_d;
	logic [FLASH_ADDR_W-1:0] addr_q, addr_d;
	logic ctrl_sel, res_sel;

	assign ctrl_sel = (reg_addr_in == FLASH_CRC_CONTROL_ADDR);
	assign res_sel = (reg_addr_in == FLASH_CRC_RESULT_ADDR);

	// Flash data passes untouched, so the ID areas are checked as stored
	crc_word_step u_step (
		.crc_in(crc_q),
		.word_in(flash_rdata_in),
		.crc_out(crc_next)
	);

	// Register writes and read data; the end of a pass overrides a result write
	always_comb begin
		enable_d = enable_q;
		range_d = range_q;
		result_d = result_q;
		rdata_d = rdata_q;
		if (reg_wr_in && ctrl_sel && reg_size_in == ACC_BYTE) begin
			enable_d = reg_wdata_in[ENGINE_ENABLE_POS];
			range_d = reg_wdata_in[RANGE_CODE_LSB +: RANGE_CODE_W];
		end else if (reg_wr_in && ctrl_sel && reg_size_in == ACC_BIT) begin
			if (reg_bit_in == 3'(ENGINE_ENABLE_POS)) begin
				enable_d = reg_wdata_in[0];
			end
		end else if (reg_wr_in && res_sel && reg_size_in == ACC_WORD && enable_q) begin
			result_d = reg_wdata_in;
		end
		if (state_q == ST_RUN && left_q == 16'h0000) begin
			result_d = crc_next;
		end
		if (reg_rd_in && ctrl_sel && reg_size_in != ACC_WORD) begin
			rdata_d = {8'h00, enable_q, 1'b0, range_q};
		end else if (reg_rd_in && res_sel && reg_size_in == ACC_WORD) begin
			rdata_d = result_q;
		end else if (reg_rd_in) begin
			rdata_d = 16'h0000;
		end
	end

	// Register state; read data stays until the next read so software may poll late
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			enable_q <= FLASH_CRC_CONTROL_RST[ENGINE_ENABLE_POS];
			range_q <= FLASH_CRC_CONTROL_RST[RANGE_CODE_W-1:0];
			result_q <= FLASH_CRC_RESULT_RST;
			rdata_q <= 16'h0000;
		end else begin
			enable_q <= enable_d;
			range_q <= range_d;
			result_q <= result_d;
			rdata_q <= rdata_d;
		end
	end

	// Pass sequencer: one word per clock from address zero upward
	always_comb begin
		state_d = state_q;
		left_d = left_q;
		crc_d = crc_q;
		hold_d = hold_q;
		release_d = 1'b0;
		rd_d = rd_q;
		addr_d = addr_q;
		case (state_q)
			ST_IDLE: begin
				if (halt_exec_in && enable_q) begin
					state_d = ST_RUN;
					left_d = pass_words(range_q) - 16'h0001;
					crc_d = result_q;
					hold_d = 1'b1;
					rd_d = 1'b1;
					addr_d = '0;
				end
			end
			ST_RUN: begin
				crc_d = crc_next;
				addr_d = addr_q + WORD_BYTES;
				left_d = left_q - 16'h0001;
				if (left_q == 16'h0000) begin
					state_d = ST_IDLE;
					hold_d = 1'b0;
					release_d = 1'b1;
					rd_d = 1'b0;
					addr_d = '0;
				end
			end
			default: begin
				state_d = ST_IDLE;
				hold_d = 1'b0;
				rd_d = 1'b0;
			end
		endcase
	end

	// Sequencer state, reset to idle with the CPU free
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= ST_IDLE;
			left_q <= 16'h0000;
			crc_q <= 16'h0000;
			hold_q <= 1'b0;
			release_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= '0;
		end else begin
			state_q <= state_d;
			left_q <= left_d;
			crc_q <= crc_d;
			hold_q <= hold_d;
			release_q <= release_d;
			rd_q <= rd_d;
			addr_q <= addr_d;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata_out = rdata_q;
	assign cpu_hold_out = hold_q;
	assign halt_release_out = release_q;
	assign flash_rd_out = rd_q;
	assign flash_addr_out = addr_q;

	// Helper: clocks spent holding the CPU and the length expected for the pass
	logic [16:0] run_cnt_q, run_cnt_d;
	logic [15:0] exp_len_q, exp_len_d;
	always_comb begin
		run_cnt_d = run_cnt_q;
		exp_len_d = exp_len_q;
		if (state_q == ST_IDLE && halt_exec_in && enable_q) begin
			run_cnt_d = 17'h00000;
			exp_len_d = pass_words(range_q);
		end else if (hold_q) begin
			run_cnt_d = run_cnt_q + 17'h00001;
		end
	end

	// Helper registers; the clock count is one bit wider than a pass so an overrun is still visible
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			run_cnt_q <= 17'h00000;
			exp_len_q <= 16'h0000;
		end else begin
			run_cnt_q <= run_cnt_d;
			exp_len_q <= exp_len_d;
		end
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_b_in);

	a_start_on_halt: assert property (
		state_q == ST_IDLE && halt_exec_in && enable_q |=>
			cpu_hold_out && flash_rd_out && flash_addr_out == '0
	) else $error("pass did not start on halt with enable set");

	a_no_start_off: assert property (
		state_q == ST_IDLE && !enable_q |=> !cpu_hold_out
	) else $error("pass started while enable clear");

	a_hold_matches_read: assert property (
		cpu_hold_out == flash_rd_out
	) else $error("cpu released while flash still being read");

	a_release_on_end: assert property (
		$fell(cpu_hold_out) |-> halt_release_out
	) else $error("hold dropped without release pulse");

	a_pass_length: assert property (
		halt_release_out |-> run_cnt_q == {1'b0, exp_len_q}
	) else $error("pass length differs from range setting");

	a_addr_ascend: assert property (
		flash_rd_out && $past(flash_rd_out) |->
			flash_addr_out == $past(flash_addr_out) + WORD_BYTES
	) else $error("flash address not stepping by one word");

	a_last_word: assert property (
		$fell(flash_rd_out) |->
			$past(flash_addr_out) == 18'(({2'b00, exp_len_q} << 2) - 18'h00004)
	) else $error("last word fetched at wrong address");

	a_result_update: assert property (
		state_q == ST_RUN && left_q == 16'h0000 |=> result_q == $past(crc_next)
	) else $error("result not loaded at pass end");

	a_result_locked: assert property (
		reg_wr_in && res_sel && !enable_q && state_q == ST_IDLE |=> $stable(result_q)
	) else $error("result written while enable clear");

	c_full_pass: cover property (halt_release_out);
	c_halt_disabled: cover property (state_q == ST_IDLE && halt_exec_in && !enable_q);
	c_result_write: cover property (reg_wr_in && res_sel && reg_size_in == ACC_WORD && enable_q);

endmodule

// ---- verification/flash_model.sv ----
// Behavioural code flash with combinational read data
module flash_model (
	// Clock
	input wire logic clk_in,
	// Read port
	input wire logic rd_in,
	input wire logic [17:0] addr_in,
	output logic [31:0] rdata_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] last_q;

	// Nonzero pattern everywhere, so unmasked ID areas show real data
	function automatic logic [31:0] word_at(input logic [17:0] a);
		return {~a[15:0], a[17:2]} ^ 32'hA5C30F1E;
	endfunction

	// Unselected bus shows the inverse of the last word, never a stale copy
	always_comb begin
		rdata_out = rd_in ? word_at(addr_in) : ~last_q;
	end

	// Remember the last word read, so an idle bus never toggles back to it
	always_ff @(posedge clk_in) begin
		if (rd_in) begin
			last_q <= rdata_out;
		end
	end
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the halt-time flash checksum engine
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import flash_crc_pkg::*;
	logic ref_clk_in, rst_b_in, reg_wr_in, reg_rd_in, halt_exec_in;
	logic [19:0] reg_addr_in;
	logic [1:0] reg_size_in;
	logic [2:0] reg_bit_in;
	logic [15:0] reg_wdata_in, reg_rdata_out, res_exp;
	logic cpu_hold_out, halt_release_out, flash_rd_out;
	logic [17:0] flash_addr_out;
	logic [31:0] flash_rdata_in;
	int err_total, checks;

	flash_halt_crc_engine #(.WORDS_PER_STEP(4)) i_dut (.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_size_in(reg_size_in), .reg_bit_in(reg_bit_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.halt_exec_in(halt_exec_in), .cpu_hold_out(cpu_hold_out),
		.halt_release_out(halt_release_out), .flash_rd_out(flash_rd_out),
		.flash_addr_out(flash_addr_out), .flash_rdata_in(flash_rdata_in));
	flash_model i_flash (.clk_in(ref_clk_in), .rd_in(flash_rd_out),
		.addr_in(flash_addr_out), .rdata_out(flash_rdata_in));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One strobe cycle; read data is settled when the task returns
	task automatic acc(input logic wr, input logic [19:0] a, input logic [1:0] sz,
		input logic [2:0] b, input logic [15:0] d);
		@(negedge ref_clk_in);
		reg_wr_in = wr;
		reg_rd_in = !wr;
		reg_addr_in = a;
		reg_size_in = sz;
		reg_bit_in = b;
		reg_wdata_in = d;
		@(negedge ref_clk_in);
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
	endtask

	// Reference remainder, bit 31 first, no reflection
	function automatic logic [15:0] crc16(input logic [15:0] c, input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h1021 : 16'h0000);
		end
		return c;
	endfunction

	task automatic t_reset;
		acc(1'b0, FLASH_CRC_CONTROL_ADDR, ACC_BYTE, 3'h0, 16'h0000);
		chk("control reset", 32'h0, reg_rdata_out);
		acc(1'b0, FLASH_CRC_RESULT_ADDR, ACC_WORD, 3'h0, 16'h0000);
		chk("result reset", 32'h0, reg_rdata_out);
		$display("test reset done");
	endtask

	task automatic t_disabled;
		acc(1'b1, FLASH_CRC_RESULT_ADDR, ACC_WORD, 3'h0, 16'h1234);
		acc(1'b0, FLASH_CRC_RESULT_ADDR, ACC_WORD, 3'h0, 16'h0000);
		chk("result write disabled", 32'h0, reg_rdata_out);
		@(negedge ref_clk_in);
		halt_exec_in = 1'b1;
		@(negedge ref_clk_in);
		halt_exec_in = 1'b0;
		repeat (4) begin
			chk("hold disabled", 32'h0, {cpu_hold_out, flash_rd_out});
			@(negedge ref_clk_in);
		end
		$display("test disabled done");
	endtask

	task automatic t_regs;
		acc(1'b1, FLASH_CRC_CONTROL_ADDR, ACC_BYTE, 3'h0, 16'h0081);
		acc(1'b1, FLASH_CRC_CONTROL_ADDR, ACC_BIT, 3'h6, 16'h0000);
		acc(1'b0, FLASH_CRC_CONTROL_ADDR, ACC_BYTE, 3'h0, 16'h0000);
		chk("control byte", 32'h81, reg_rdata_out);
		acc(1'b1, FLASH_CRC_CONTROL_ADDR, ACC_BIT, 3'h7, 16'h0000);
		acc(1'b0, FLASH_CRC_CONTROL_ADDR, ACC_BYTE, 3'h0, 16'h0000);
		chk("enable bit clear", 32'h01, reg_rdata_out);
		acc(1'b1, FLASH_CRC_CONTROL_ADDR, ACC_BIT, 3'h7, 16'h0001);
		acc(1'b1, FLASH_CRC_RESULT_ADDR, ACC_WORD, 3'h0, 16'hBEEF);
		acc(1'b1, FLASH_CRC_RESULT_ADDR, ACC_BYTE, 3'h0, 16'h0055);
		acc(1'b0, FLASH_CRC_RESULT_ADDR, ACC_WORD, 3'h0, 16'h0000);
		chk("result word write", 32'hBEEF, reg_rdata_out);
		acc(1'b0, FLASH_CRC_RESULT_ADDR, ACC_BYTE, 3'h0, 16'h0000);
		chk("result byte read", 32'h0, reg_rdata_out);
		acc(1'b1, FLASH_CRC_CONTROL_ADDR, ACC_WORD, 3'h0, 16'h0000);
		acc(1'b0, FLASH_CRC_CONTROL_ADDR, ACC_WORD, 3'h0, 16'h0000);
		chk("control word read", 32'h0, reg_rdata_out);
		acc(1'b0, FLASH_CRC_CONTROL_ADDR, ACC_BYTE, 3'h0, 16'h0000);
		chk("control after word write", 32'h81, reg_rdata_out);
		res_exp = 16'hBEEF;
		$display("test registers done");
	endtask

	// Halt pass: counts held cycles, follows addresses, repeats halt mid-pass
	task automatic t_pass(input logic [7:0] ctl, input int n);
		int k;
		acc(1'b1, FLASH_CRC_CONTROL_ADDR, ACC_BYTE, 3'h0, {8'h00, ctl});
		@(negedge ref_clk_in);
		halt_exec_in = 1'b1;
		@(negedge ref_clk_in);
		k = 0;
		while (cpu_hold_out === 1'b1 && k < 300) begin
			chk("flash address", 4 * k, flash_addr_out);
			chk("flash read", 32'h1, flash_rd_out);
			res_exp = crc16(res_exp, i_flash.word_at(18'(4 * k)));
			k++;
			halt_exec_in = (k == 2);
			@(negedge ref_clk_in);
		end
		halt_exec_in = 1'b0;
		chk("pass length", n, k);
		chk("release pulse", 32'h1, halt_release_out);
		acc(1'b0, FLASH_CRC_RESULT_ADDR, ACC_WORD, 3'h0, 16'h0000);
		chk("pass result", res_exp, reg_rdata_out);
		$display("test pass %h done", ctl);
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Clock, 5 ns period
	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end

	// Generous bound: the whole sequence needs well under 2000 cycles
	initial begin
		#100000;
		err_total++;
		final_report();
	end

	// Main sequence
	initial begin
		{rst_b_in, reg_wr_in, reg_rd_in, halt_exec_in} = 4'h0;
		reg_addr_in = 20'h00000;
		reg_size_in = 2'h0;
		reg_bit_in = 3'h0;
		reg_wdata_in = 16'h0000;
		err_total = 0;
		checks = 0;
		repeat (12) @(negedge ref_clk_in);
		rst_b_in = 1'b1;
		t_reset();
		t_disabled();
		t_regs();
		t_pass(8'h81, 7);
		t_pass(8'h80, 3);
		t_pass(8'hBF, 63);
		final_report();
	end
endmodule
